// >>> logic/pcmc_ctrl.sv
// Power and clock mode controller with Avalon-MM register slave
// Notes on behaviour
// RULE_01: Unblocked enabled external interrupt restores full speed
// RULE_02: Start bit on enabled receiver restores speed
// RULE_03: Transmit buffer write restores full speed
// RULE_04: Switchback only while enable bit is set
// RULE_05: Priority-blocked external interrupt gives no switchback
// RULE_06: Status bits 7..5 show levels in service
// RULE_07: Status bits 3..0 show serial activity
// RULE_08: Software checks serial idle before slowing
// RULE_09: Source select bit, crystal after reset
// RULE_10: Read-only bit shows ring as active source
// RULE_11: Crystal stop accepted only with ring selected
// RULE_12: Source change applies next instruction cycle
// RULE_13: Crystal ready after warm-up count
// RULE_14: Crystal select refused until crystal ready
// RULE_15: Switchback leaves the clock source alone
// RULE_16: Idle halts CPU, any interrupt ends it
// RULE_17: Stop halts all, external interrupt ends
// RULE_18: Bandgap kept on in stop when chosen
// RULE_19: Bandgap bit ignored outside stop
// RULE_20: Ring wake hands over to crystal later
// RULE_21: Software may restore speed by divider write
// RULE_22: Software may mask switchback by priority level
// RULE_23: Switchback rewrites divider bits to full speed
`timescale 1ns/10ps
module pcmc_ctrl
   import pcmc_pkg::*;
#(
   parameter int unsigned WARMUP = WARMUP_CLOCKS
) (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [9:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire pcmc_evt_s   evt,
   output pcmc_pwr_s        pwr
);

   // ****************************************************
   // Declarations
   // ****************************************************
   pcmc_mode_e mode_r;
   logic [31:0] rdata_r;
   logic        wait_r;
   logic [5:0]  power_control_reg_hi_r;
   logic        sel_r;
   logic        rwake_r;
   logic        bgs_r;
   logic        ract_r;
   logic        src_pend_r;
   logic        hand_pend_r;
   logic [1:0]  div_r;
   logic        swb_r;
   logic        xoff_r;
   logic [2:0]  pmr_lo_r;
   logic [9:0]  cyc_r;
   pcmc_pwr_s   pwr_r;
   logic        xrdy;
   logic [5:0]  src_ok;
   logic        ext_ok;
   logic        swb_evt;
   logic        go_wr;
   logic        power_control_reg_wr;
   logic        ext_flag_clock_select_wr;
   logic        pmr_wr;
   logic [7:0]  wd;
   logic        sel_wval;
   logic        stop_wake;
   logic        wake_ring;
   logic        handover;
   logic        amp_on;
   logic        instr_en;
   logic [9:0]  cyc_last;
   logic [7:0]  rd_mux;

   // ****************************************************
   // Avalon-MM slave
   // ****************************************************
   assign wd      = writedata[7:0];
   assign go_wr   = write && !wait_r;
   assign power_control_reg_wr = go_wr && (address[9:2] == IDX_POWER_CONTROL_REG);
   assign ext_flag_clock_select_wr = go_wr && (address[9:2] == IDX_EXT_FLAG_CLOCK_SELECT);
   assign pmr_wr  = go_wr && (address[9:2] == IDX_PMR);

   // Read mux; unmapped words and reserved bits read as zero
   always_comb begin
      rd_mux = 8'h00;
      case (address[9:2])
         IDX_POWER_CONTROL_REG: begin
            rd_mux = {power_control_reg_hi_r, mode_r == MODE_STOP,
                      mode_r == MODE_IDLE};
         end
         IDX_EXT_FLAG_CLOCK_SELECT: begin
            rd_mux = {4'h0, sel_r, ract_r, rwake_r, bgs_r}; // RULE_09 RULE_10
         end
         IDX_PMR: begin
            rd_mux = {div_r, swb_r, 1'b0, xoff_r, pmr_lo_r};
         end
         IDX_STATUS: begin
            rd_mux = {evt.lvl_pf, evt.lvl_hi, evt.lvl_lo, xrdy, // RULE_06 RULE_13
                      evt.tx_act[1], evt.rx_act[1],            // RULE_07
                      evt.tx_act[0], evt.rx_act[0]};           // RULE_07
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // One wait cycle per access; data stand on the cycle wait is low
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if ((read || write) && wait_r) begin
         wait_r  <= 1'b0;
         rdata_r <= {24'h000000, read ? rd_mux : 8'h00};
      end else begin
         wait_r  <= 1'b1;
      end
   end

   assign readdata    = rdata_r;
   assign waitrequest = wait_r;

   // ****************************************************
   // Switchback sources
   // ****************************************************
   // A source counts only if the interrupt logic would really take it
   for (genvar i = 0; i < 6; i++) begin : g_src
      assign src_ok[i] = evt.irq_pend[i] && evt.irq_en[i] &&
         (evt.irq_hipri[i] ? !(evt.lvl_pf || evt.lvl_hi)
                           : !(evt.lvl_pf || evt.lvl_hi || evt.lvl_lo)); // RULE_05
   end
   assign ext_ok  = |src_ok;
   assign swb_evt = swb_r && (mode_r != MODE_STOP) &&       // RULE_04
                    (ext_ok ||                              // RULE_01
                     |(evt.rx_start & evt.rx_en) ||         // RULE_02
                     |evt.tx_load);                         // RULE_03

   // ****************************************************
   // Power management register
   // ****************************************************
   // Switchback wins over a same-cycle software divider write
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_r <= PMR_RST[PMR_DIV_LO +: 2];
      end else if (swb_evt) begin
         div_r <= DIV_FULL; // RULE_23
      end else if (pmr_wr) begin
         div_r <= wd[PMR_DIV_LO +: 2];
      end
   end

   // Plain stored bits of the power management register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         swb_r    <= PMR_RST[PMR_SWB];
         pmr_lo_r <= PMR_RST[2:0];
      end else if (pmr_wr) begin
         swb_r    <= wd[PMR_SWB];
         pmr_lo_r <= wd[2:0];
      end
   end

   // Crystal stop refused while the crystal is still selected
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         xoff_r <= PMR_RST[PMR_XOFF];
      end else if (wake_ring) begin
         xoff_r <= 1'b0;
      end else if (pmr_wr && (!wd[PMR_XOFF] || !sel_r)) begin
         xoff_r <= wd[PMR_XOFF]; // RULE_11
      end
   end

   // ****************************************************
   // Clock source selection
   // ****************************************************
   assign amp_on    = !xoff_r && (mode_r != MODE_STOP);
   assign sel_wval  = (wd[EXT_FLAG_CLOCK_SELECT_SEL] && !xrdy) ? sel_r : wd[EXT_FLAG_CLOCK_SELECT_SEL];
   assign handover  = hand_pend_r && xrdy && (mode_r == MODE_RUN);
   assign stop_wake = ext_ok || (bgs_r && evt.powerfail_interrupt);          // RULE_17 RULE_18
   assign wake_ring = (mode_r == MODE_STOP) && stop_wake && rwake_r;

   // Select bit; a crystal request before warm-up is dropped
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sel_r <= EXT_FLAG_CLOCK_SELECT_RST[EXT_FLAG_CLOCK_SELECT_SEL]; // RULE_09
      end else if (wake_ring) begin
         sel_r <= 1'b0;
      end else if (handover) begin
         sel_r <= 1'b1; // RULE_20
      end else if (ext_flag_clock_select_wr) begin
         sel_r <= sel_wval; // RULE_14
      end
   end

   // Other software bits of the extended flag register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rwake_r <= EXT_FLAG_CLOCK_SELECT_RST[EXT_FLAG_CLOCK_SELECT_RWAKE];
         bgs_r   <= EXT_FLAG_CLOCK_SELECT_RST[EXT_FLAG_CLOCK_SELECT_BGS];
      end else if (ext_flag_clock_select_wr) begin
         rwake_r <= wd[EXT_FLAG_CLOCK_SELECT_RWAKE];
         bgs_r   <= wd[EXT_FLAG_CLOCK_SELECT_BGS];
      end
   end

   // Source change waits for the next instruction cycle boundary
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         src_pend_r <= 1'b0;
      end else if (wake_ring || handover) begin
         src_pend_r <= 1'b0;
      end else if (ext_flag_clock_select_wr) begin
         src_pend_r <= (sel_wval == ract_r);
      end else if (instr_en && amp_on) begin
         src_pend_r <= 1'b0;
      end
   end

   // Active source; switchback never touches it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ract_r <= ~EXT_FLAG_CLOCK_SELECT_RST[EXT_FLAG_CLOCK_SELECT_SEL];
      end else if (wake_ring) begin
         ract_r <= 1'b1;
      end else if (handover) begin
         ract_r <= 1'b0; // RULE_20
      end else if (src_pend_r && instr_en && amp_on && !ext_flag_clock_select_wr) begin
         ract_r <= !sel_r; // RULE_12 RULE_15
      end
   end

   // Pending automatic handover after a ring-clocked wake
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hand_pend_r <= 1'b0;
      end else if (wake_ring) begin
         hand_pend_r <= 1'b1;
      end else if (handover || ext_flag_clock_select_wr) begin
         hand_pend_r <= 1'b0;
      end
   end

   // Warm-up counts only while the oscillator really runs
   pcmc_warmup #(
      .COUNT (WARMUP)
   ) u_warmup (
      .clock  (clock),
      .nrst   (nrst),
      .run    (amp_on && evt.osc_started),
      .done_r (xrdy)
   ); // RULE_13

   // ****************************************************
   // Instruction cycle divider
   // ****************************************************
   always_comb begin
      case (div_r)
         DIV_MID: begin
            cyc_last = CPC_MID;
         end
         DIV_SLOW: begin
            cyc_last = CPC_SLOW;
         end
         default: begin
            cyc_last = CPC_FULL;
         end
      endcase
   end
   assign instr_en = (cyc_r >= cyc_last) && (mode_r != MODE_STOP);

   // Cleared to zero in stop, since no internal clock runs there
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cyc_r <= 10'h000;
      end else if (mode_r == MODE_STOP) begin
         cyc_r <= 10'h000;
      end else if (instr_en) begin
         cyc_r <= 10'h000;
      end else begin
         cyc_r <= cyc_r + 10'h001;
      end
   end

   // ****************************************************
   // Idle and stop
   // ****************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_r <= MODE_RUN;
      end else begin
         case (mode_r)
            MODE_RUN: begin
               if (power_control_reg_wr && wd[POWER_CONTROL_REG_STOP]) begin
                  mode_r <= MODE_STOP; // RULE_17
               end else if (power_control_reg_wr && wd[POWER_CONTROL_REG_IDLE]) begin
                  mode_r <= MODE_IDLE; // RULE_16
               end
            end
            MODE_IDLE: begin
               if (evt.any_irq) begin
                  mode_r <= MODE_RUN; // RULE_16
               end
            end
            MODE_STOP: begin
               if (stop_wake) begin
                  mode_r <= rwake_r ? MODE_RUN : MODE_WAKE; // RULE_17
               end
            end
            MODE_WAKE: begin
               if (xrdy) begin
                  mode_r <= MODE_RUN;
               end
            end
            default: begin
               mode_r <= MODE_RUN;
            end
         endcase
      end
   end

   // General purpose bits of the power control register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         power_control_reg_hi_r <= POWER_CONTROL_REG_RST[7:2];
      end else if (power_control_reg_wr) begin
         power_control_reg_hi_r <= wd[7:2];
      end
   end

   // ****************************************************
   // Outputs, registered one cycle behind the state
   // ****************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pwr_r <= '0;
      end else begin
         pwr_r.cpu_halt       <= (mode_r != MODE_RUN);
         pwr_r.clocks_stopped <= (mode_r == MODE_STOP);
         pwr_r.xtal_amp_on    <= amp_on;
         pwr_r.ring_active    <= ract_r;
         pwr_r.bandgap_on     <= (mode_r != MODE_STOP) || bgs_r; // RULE_18 RULE_19
         pwr_r.instr_en       <= instr_en;
         pwr_r.divider        <= div_r;
      end
   end
   assign pwr = pwr_r;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_slow_ext;
      swb_r && ext_ok && (mode_r != MODE_STOP);
   endsequence

   sequence s_full_after;
      ##1 (div_r == DIV_FULL) ##1 (pwr.divider == DIV_FULL);
   endsequence

   chk_swb_ext: assert property (s_slow_ext |-> s_full_after) // RULE_01
      else $error("external interrupt did not restore speed");
   chk_swb_rx: assert property ( // RULE_02
      swb_r && |(evt.rx_start & evt.rx_en) && (mode_r != MODE_STOP)
      |=> div_r == DIV_FULL)
      else $error("start bit did not restore speed");
   chk_swb_tx: assert property ( // RULE_03
      swb_r && |evt.tx_load && (mode_r != MODE_STOP)
      |=> div_r == DIV_FULL)
      else $error("transmit load did not restore speed");
   chk_swb_off: assert property (!swb_r && !pmr_wr |=> $stable(div_r)) // RULE_04
      else $error("divider moved with switchback disabled");
   chk_blocked_lo: assert property ( // RULE_05
      evt.lvl_hi && !(|(evt.irq_pend & evt.irq_en & evt.irq_hipri))
      |-> !ext_ok)
      else $error("blocked interrupt counted as wake source");
   chk_amp_guard: assert property ($rose(xoff_r) |-> !$past(sel_r)) // RULE_11
      else $error("crystal stopped while selected");
   // Every route to the crystal, write or handover, needs it ready first
   chk_sel_guard: assert property ($rose(sel_r) |-> $past(xrdy)) // RULE_14
      else $error("crystal selected before ready");
   chk_ready_off: assert property (xoff_r |=> ##1 !xrdy) // RULE_13
      else $error("crystal ready with amplifier off");
   chk_src_keep: assert property (swb_evt && !src_pend_r && // RULE_15
      !handover && !wake_ring |=> $stable(ract_r))
      else $error("switchback changed the clock source");
   chk_idle_exit: assert property ( // RULE_16
      (mode_r == MODE_IDLE) && evt.any_irq |=> ##1 !pwr.cpu_halt)
      else $error("idle not left on interrupt");
   chk_gap_stop: assert property ((mode_r == MODE_STOP) && // RULE_18
      !bgs_r |=> !pwr.bandgap_on)
      else $error("bandgap on in stop without request");
   chk_ring_hand: assert property (handover |=> sel_r && !ract_r) // RULE_20
      else $error("ring handover did not select crystal");

endmodule // pcmc_ctrl

// >>> shared/pcmc_pkg.sv
// Shared constants and carrier types of the power and clock mode control
package pcmc_pkg;

   // ****************************************************
   // Register map: printed indices, byte address = 4*index
   // ****************************************************
   localparam logic [7:0] IDX_POWER_CONTROL_REG   = 8'h87;
   localparam logic [7:0] IDX_EXT_FLAG_CLOCK_SELECT   = 8'h91;
   localparam logic [7:0] IDX_PMR    = 8'hc4;
   localparam logic [7:0] IDX_STATUS = 8'hc5;

   // Field positions
   localparam int unsigned POWER_CONTROL_REG_IDLE  = 0;
   localparam int unsigned POWER_CONTROL_REG_STOP  = 1;
   localparam int unsigned EXT_FLAG_CLOCK_SELECT_BGS   = 0;
   localparam int unsigned EXT_FLAG_CLOCK_SELECT_RWAKE = 1;
   localparam int unsigned EXT_FLAG_CLOCK_SELECT_RACT  = 2;
   localparam int unsigned EXT_FLAG_CLOCK_SELECT_SEL   = 3;
   localparam int unsigned PMR_XOFF   = 3;
   localparam int unsigned PMR_SWB    = 5;
   localparam int unsigned PMR_DIV_LO = 6;
   localparam int unsigned ST_XRDY    = 4;

   // Reset values
   localparam logic [7:0] POWER_CONTROL_REG_RST = 8'h00;
   localparam logic [7:0] EXT_FLAG_CLOCK_SELECT_RST = 8'h08;
   localparam logic [7:0] PMR_RST  = 8'h80;

   // Divider settings and last clock count of each instruction cycle (one less than its clocks)
   localparam logic [1:0] DIV_FULL = 2'h2;
   localparam logic [1:0] DIV_MID  = 2'h3;
   localparam logic [1:0] DIV_SLOW = 2'h0;
   localparam logic [9:0] CPC_FULL = 10'h003;
   localparam logic [9:0] CPC_MID  = 10'h03f;
   localparam logic [9:0] CPC_SLOW = 10'h3ff;

   // Crystal warm-up and ring handover interval in clocks
   localparam int unsigned WARMUP_CLOCKS = 65536;

   typedef enum logic [1:0] {
      MODE_RUN, MODE_IDLE, MODE_STOP, MODE_WAKE
   } pcmc_mode_e;

   // Events and levels from CPU core, interrupt logic and serial ports
   typedef struct packed {
      logic [5:0] irq_pend;
      logic [5:0] irq_en;
      logic [5:0] irq_hipri;
      logic       lvl_pf;
      logic       lvl_hi;
      logic       lvl_lo;
      logic       any_irq;
      logic       powerfail_interrupt;
      logic [1:0] rx_start;
      logic [1:0] rx_en;
      logic [1:0] tx_load;
      logic [1:0] rx_act;
      logic [1:0] tx_act;
      logic       osc_started;
   } pcmc_evt_s;

   // Clock and power controls toward the chip
   typedef struct packed {
      logic       cpu_halt;
      logic       clocks_stopped;
      logic       xtal_amp_on;
      logic       ring_active;
      logic       bandgap_on;
      logic       instr_en;
      logic [1:0] divider;
   } pcmc_pwr_s;

endpackage

// >>> logic/pcmc_warmup.sv
// Crystal warm-up interval counter
`timescale 1ns/10ps
module pcmc_warmup
   import pcmc_pkg::*;
#(
   parameter int unsigned COUNT = WARMUP_CLOCKS
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic run,
   output logic      done_r
);
   localparam int unsigned W = $clog2(COUNT + 1);
   localparam logic [W-1:0] LAST = W'(COUNT - 1);

   logic [W-1:0] cnt_r;

   // Any pause of the oscillator restarts the whole interval
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (!run) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (!done_r) begin
         cnt_r  <= cnt_r + W'(1);
         done_r <= (cnt_r == LAST);
      end
   end
endmodule // pcmc_warmup

// >>> bench/pcmc_core_model.sv
// Model of the CPU core, interrupt logic and serial ports
`timescale 1ns/10ps
module pcmc_core_model
   import pcmc_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      nrst,
   input  wire pcmc_pwr_s pwr,
   output pcmc_evt_s      evt
);
   pcmc_evt_s  lvl_r;
   logic [1:0] rxs_r;
   logic [1:0] txl_r;
   logic [2:0] osc_r;

   initial begin
      lvl_r = '0;
      rxs_r = 2'h0;
      txl_r = 2'h0;
   end

   // Crystal needs clocks to start and dies with its amplifier or in stop
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) osc_r <= 3'h0;
      else if (!pwr.xtal_amp_on || pwr.clocks_stopped) osc_r <= 3'h0;
      else if (osc_r != 3'h5) osc_r <= osc_r + 3'h1;
   end

   // Levels as set; start bit and buffer write are one-cycle pulses
   always_comb begin
      evt             = lvl_r;
      evt.rx_start    = rxs_r;
      evt.tx_load     = txl_r;
      evt.osc_started = (osc_r == 3'h5);
   end

   task automatic set_lvl(input pcmc_evt_s v);
      @(posedge clock);
      lvl_r <= v;
   endtask

   task automatic pulse(input logic [1:0] rx, input logic [1:0] tx);
      @(posedge clock);
      rxs_r <= rx;
      txl_r <= tx;
      @(posedge clock);
      rxs_r <= 2'h0;
      txl_r <= 2'h0;
   endtask
endmodule // pcmc_core_model

// >>> bench/test_pcmc_ctrl.sv
// Self-checking bench of the power and clock mode controller
`timescale 1ns/10ps
module test_pcmc_ctrl
   import pcmc_pkg::*;
   ;
   // Short warm-up keeps the run brief; only the warm-up wait derives from it
   localparam int unsigned WARM = 16;
   logic        clock;
   logic        nrst;
   logic [9:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   pcmc_evt_s   evt;
   pcmc_pwr_s   pwr;
   pcmc_evt_s   ev;
   int          mismatches;
   int          check_count;
   int          cycles = 0;
   int          pulses;

   pcmc_ctrl #(.WARMUP(WARM)) i_dut (.clock(clock), .nrst(nrst),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .evt(evt), .pwr(pwr));
   pcmc_core_model i_core (.clock(clock), .nrst(nrst), .pwr(pwr),
      .evt(evt));

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string n, input logic [7:0] e,
                        input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   // ****************************************************
   // Avalon master: hold the request until waitrequest is low
   // ****************************************************
   task automatic bus_write(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clock);
      address   <= {idx, 2'h0};
      writedata <= {24'h5a5a5a, d}; // Upper bits must be ignored
      write     <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      write <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] idx, output logic [7:0] d);
      @(posedge clock);
      address <= {idx, 2'h0};
      read    <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      d = readdata[7:0];
      read <= 1'b0;
   endtask

   task automatic expect_reg(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] v;
      bus_read(idx, v);
      check($sformatf("reg %h", idx), e, v);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Polls until the value shows; only the hang guard ends it
   task automatic poll_reg(input logic [7:0] idx, input logic [7:0] val);
      logic [7:0] v;
      v = ~val;
      while (v !== val) bus_read(idx, v);
   endtask

   task automatic wait_run();
      while (pwr.cpu_halt !== 1'b0) @(posedge clock);
   endtask

   // One event with chosen enable and divider, then divider read back
   task automatic sb_try(input logic [7:0] pm, input pcmc_evt_s e,
                         input logic [1:0] rx, input logic [1:0] tx,
                         input logic [7:0] exp);
      bus_write(IDX_PMR, pm);
      i_core.set_lvl(e);
      i_core.pulse(rx, tx);
      settle(6);
      i_core.set_lvl('0);
      expect_reg(IDX_PMR, exp);
      check("divider", {6'h0, exp[7:6]}, {6'h0, pwr.divider});
   endtask

   // ****************************************************
   // Test sequence
   // ****************************************************
   initial begin
      nrst = 1'b0;
      address = 10'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      mismatches = 0;
      check_count = 0;
      ev = '0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      expect_reg(IDX_POWER_CONTROL_REG, POWER_CONTROL_REG_RST);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, EXT_FLAG_CLOCK_SELECT_RST);
      expect_reg(IDX_PMR, PMR_RST);
      expect_reg(8'h20, 8'h00);
      poll_reg(IDX_STATUS, 8'h10);
      // Service levels and serial activity as seen in status
      ev.lvl_pf = 1'b1;
      ev.lvl_lo = 1'b1;
      ev.rx_act = 2'h1;
      ev.tx_act = 2'h2;
      i_core.set_lvl(ev);
      expect_reg(IDX_STATUS, 8'hb9);
      ev = '0;
      ev.lvl_hi = 1'b1;
      ev.rx_act = 2'h2;
      ev.tx_act = 2'h1;
      i_core.set_lvl(ev);
      expect_reg(IDX_STATUS, 8'h56);
      i_core.set_lvl('0);
      expect_reg(IDX_STATUS, 8'h10);
      // Switchback sources, gated by enable and by priority level
      sb_try(8'h00, '0, 2'h0, 2'h1, 8'h00);
      sb_try(8'h20, '0, 2'h0, 2'h2, 8'ha0);
      ev = '0;
      ev.rx_en = 2'h2;
      sb_try(8'h20, ev, 2'h1, 2'h0, 8'h20);
      sb_try(8'h20, ev, 2'h2, 2'h0, 8'ha0);
      ev = '0;
      ev.irq_pend = 6'h05;
      ev.irq_en = 6'h01;
      ev.lvl_lo = 1'b1;
      sb_try(8'h20, ev, 2'h0, 2'h0, 8'h20);
      ev.lvl_lo = 1'b0;
      ev.lvl_hi = 1'b1;
      sb_try(8'he0, ev, 2'h0, 2'h0, 8'he0);
      ev = '0;
      ev.irq_pend = 6'h02;
      ev.irq_en = 6'h02;
      ev.irq_hipri = 6'h02;
      ev.lvl_lo = 1'b1;
      sb_try(8'h20, ev, 2'h0, 2'h0, 8'ha0);
      ev = '0;
      ev.irq_pend = 6'h20;
      ev.irq_en = 6'h20;
      sb_try(8'he0, ev, 2'h0, 2'h0, 8'ha0);
      bus_write(IDX_PMR, 8'h20);
      bus_write(IDX_PMR, 8'h80);
      // Divider output lags the register by one clock
      settle(2);
      check("divider", 8'h02, {6'h0, pwr.divider});
      // Full speed: one instruction pulse every four clocks
      pulses = 0;
      repeat (16) begin
         @(posedge clock);
         if (pwr.instr_en === 1'b1) pulses++;
      end
      check("instr_en pulses", 8'h04, pulses[7:0]);
      // Crystal stop refused with crystal selected, then ring source
      bus_write(IDX_PMR, 8'h88);
      expect_reg(IDX_PMR, 8'h80);
      bus_write(IDX_EXT_FLAG_CLOCK_SELECT, 8'h00);
      settle(6);
      check_bit("ring_active", 1'b1, pwr.ring_active);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h04);
      bus_write(IDX_PMR, 8'h88);
      expect_reg(IDX_PMR, 8'h88);
      check_bit("xtal_amp_on", 1'b0, pwr.xtal_amp_on);
      sb_try(8'h28, '0, 2'h0, 2'h1, 8'ha8);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h04);
      bus_write(IDX_EXT_FLAG_CLOCK_SELECT, 8'h08);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h04);
      bus_write(IDX_PMR, 8'h80);
      settle(WARM);
      expect_reg(IDX_STATUS, 8'h00);
      poll_reg(IDX_STATUS, 8'h10);
      bus_write(IDX_EXT_FLAG_CLOCK_SELECT, 8'h08);
      settle(6);
      check_bit("ring_active", 1'b0, pwr.ring_active);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h08);
      // Idle keeps clocks and bandgap; any interrupt ends it
      bus_write(IDX_POWER_CONTROL_REG, 8'h01);
      expect_reg(IDX_POWER_CONTROL_REG, 8'h01);
      check_bit("cpu_halt", 1'b1, pwr.cpu_halt);
      check_bit("clocks_stopped", 1'b0, pwr.clocks_stopped);
      check_bit("bandgap_on", 1'b1, pwr.bandgap_on);
      ev = '0;
      ev.any_irq = 1'b1;
      i_core.set_lvl(ev);
      settle(3);
      i_core.set_lvl('0);
      check_bit("cpu_halt", 1'b0, pwr.cpu_halt);
      expect_reg(IDX_POWER_CONTROL_REG, 8'h00);
      // Stop, bandgap off: internal and power-fail sources do not wake
      bus_write(IDX_POWER_CONTROL_REG, 8'h02);
      settle(2);
      check_bit("clocks_stopped", 1'b1, pwr.clocks_stopped);
      check_bit("bandgap_on", 1'b0, pwr.bandgap_on);
      ev.any_irq = 1'b1;
      ev.powerfail_interrupt = 1'b1;
      i_core.set_lvl(ev);
      settle(6);
      check_bit("clocks_stopped", 1'b1, pwr.clocks_stopped);
      ev.irq_pend = 6'h01;
      ev.irq_en = 6'h01;
      i_core.set_lvl(ev);
      settle(3);
      i_core.set_lvl('0);
      check_bit("clocks_stopped", 1'b0, pwr.clocks_stopped);
      wait_run();
      check_bit("bandgap_on", 1'b1, pwr.bandgap_on);
      // Stop with bandgap kept: power-fail warning wakes
      bus_write(IDX_EXT_FLAG_CLOCK_SELECT, 8'h09);
      bus_write(IDX_POWER_CONTROL_REG, 8'h02);
      settle(2);
      check_bit("bandgap_on", 1'b1, pwr.bandgap_on);
      ev = '0;
      ev.powerfail_interrupt = 1'b1;
      i_core.set_lvl(ev);
      settle(3);
      i_core.set_lvl('0);
      check_bit("clocks_stopped", 1'b0, pwr.clocks_stopped);
      wait_run();
      // Ring as wake clock, then automatic handover to the crystal
      bus_write(IDX_EXT_FLAG_CLOCK_SELECT, 8'h0b);
      bus_write(IDX_POWER_CONTROL_REG, 8'h02);
      settle(2);
      ev = '0;
      ev.irq_pend = 6'h02;
      ev.irq_en = 6'h02;
      i_core.set_lvl(ev);
      settle(4);
      i_core.set_lvl('0);
      check_bit("cpu_halt", 1'b0, pwr.cpu_halt);
      check_bit("ring_active", 1'b1, pwr.ring_active);
      expect_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h07);
      poll_reg(IDX_EXT_FLAG_CLOCK_SELECT, 8'h0b);
      check_bit("ring_active", 1'b0, pwr.ring_active);
      print_verdict();
   end
endmodule // test_pcmc_ctrl
